// ==== pns_bank.sv ====
// Paged nibble register bank with APB access, ports and PWM sample registers
//
// Contract
// (RULE1) 128 SRAM nibbles in four selectable pages
// (RULE2) Software loads page select before SRAM use
// (RULE3) 00H-1FH always reach the special registers
// (RULE4) 20H-3FH reach the selected SRAM page
// (RULE5) SRAM contents are not reset
// (RULE6) Bit set/clear only on 00H-0FH
// (RULE7) Every special register reads/writes whole nibbles
// (RULE8) Scratch nibbles at 07H and 0FH
// (RULE9) Direction bit 1 means output, reset 0000
// (RULE10) Port read gives pins, write sets latch
// (RULE11) Port C output only, resets to 0000
// (RULE12) Status: irq flag, carry, zero; top bits reset
// (RULE13) Control: PWM enable bit0, irq enable bit1
// (RULE14) Eight bit sample: low then high nibble
// (RULE15) Ten bit sample layout from three nibbles
// (RULE16) Twelve bit sample layout from three nibbles
// (RULE17) High nibble bit 3 is the sign
// (RULE18) Format bit: 1 two's complement, reset 0
// (RULE19) Hysteresis enable for port A, reset off
// (RULE20) Software clears the PWM irq flag
// (RULE21) Reserved 10H and 12H ignore writes, read quietly
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "pns_defs.svh"

module pns_bank (
  input  wire logic              pclk,            // Clock, 50 MHz
  input  wire logic              presetn,         // Async reset, low
  input  wire logic              psel,            // APB select
  input  wire logic              penable,         // APB enable
  input  wire logic              pwrite,          // APB direction
  input  wire logic [31:0]       paddr,           // APB byte address
  input  wire logic [31:0]       pwdata,          // APB write data
  output logic      [31:0]       prdata,          // APB read data
  output logic                   pready,          // APB ready
  output logic                   pslverr,         // APB error
  input  wire pns_pkg::pns_pins_t pin_in,         // Pin levels
  output pns_pkg::pns_pins_t     pin_out,         // Pin drive values
  output pns_pkg::pns_pins_t     pin_oe_n,        // Pin enables, low drives
  output logic      [3:0]        port_c_out,      // Port C pins
  input  wire logic              pwm_irq_event,   // PWM request pulse
  input  wire logic              alu_flag_load,   // Core updates flags
  input  wire logic              alu_carry,       // New carry
  input  wire logic              alu_zero,        // New zero
  input  wire logic              ten_bit_option,  // Ten bit fuse
  input  wire logic              twelve_bit_option, // Twelve bit fuse
  output logic      [11:0]       pwm_sample,      // Assembled sample
  output logic                   sample_sign,     // Sample sign bit
  output logic                   sample_format_select, // Two's format
  output logic                   pwm_output_enable,    // PWM enable
  output logic                   global_irq_enable,    // Irq enable
  output logic                   pwm_irq_flag,         // Irq flag
  output logic                   hysteresis_input_enable, // Port A hysteresis
  output logic      [1:0]        page_select           // Current page
);

  import pns_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  pns_state_t  st;         // Registered state
  pns_state_t  next_st;    // Next state
  logic [6:0]  acc_idx;    // Register index of access
  logic        addr_ok;    // Address inside the map
  logic        acc_first;  // First access cycle
  logic        acc_done;   // Completing access cycle
  logic        wr_en;      // Nibble write strobe
  logic [6:0]  wr_idx;     // Nibble write index
  logic [3:0]  wr_val;     // Nibble write value
  logic [3:0]  ram_rdata;  // SRAM read nibble
  logic [11:0] asm_sample; // Assembled sample
  logic [5:0]  bo_tgt;     // Bit op target
  logic [1:0]  bo_bit;     // Bit op position
  logic [3:0]  bo_cur;     // Bit op current nibble
  logic [3:0]  bo_new;     // Bit op result nibble
  logic        ram_wr;     // SRAM write strobe

  // ---------------------------------------------------------------
  // Nibble view of a special register
  // ---------------------------------------------------------------
  // Ports show pins on plain reads, latches for bit modify
  function automatic logic [3:0] nib_read(input logic [6:0] idx,
                                          input logic       use_latch);
    logic [3:0] v;
    v = 4'h0;
    unique case (idx)  // (RULE3)
      `PNS_IDX_STATUS:   v = {1'b0, st.flags};                          // (RULE12)
      `PNS_IDX_E_DIR:    v = ~st.dir_n.e;                               // (RULE9)
      `PNS_IDX_A_DIR:    v = ~st.dir_n.a;
      `PNS_IDX_A_VAL:    v = use_latch ? st.latch.a : pin_in.a;         // (RULE10)
      `PNS_IDX_C_OUT:    v = st.port_c;                                 // (RULE11)
      `PNS_IDX_B_DIR:    v = ~st.dir_n.b;
      `PNS_IDX_B_VAL:    v = use_latch ? st.latch.b : pin_in.b;
      `PNS_IDX_SCRATCH1: v = st.scratch1;                               // (RULE8)
      `PNS_IDX_SMP_XLO:  v = use_latch ? st.smp_xlo : 4'h0;
      `PNS_IDX_PWM_CTRL: v = {2'h0, st.gie, st.pwm_en};                 // (RULE13)
      `PNS_IDX_SMP_LO:   v = use_latch ? st.smp_lo : 4'h0;
      `PNS_IDX_SMP_HI:   v = use_latch ? st.smp_hi : 4'h0;
      `PNS_IDX_D_DIR:    v = ~st.dir_n.d;
      `PNS_IDX_D_VAL:    v = use_latch ? st.latch.d : pin_in.d;
      `PNS_IDX_E_VAL:    v = use_latch ? st.latch.e : pin_in.e;
      `PNS_IDX_SCRATCH2: v = st.scratch2;
      `PNS_IDX_FMT_CTRL: v = {1'b0, st.hyst, st.fmt_2s, 1'b0};          // (RULE18)
      `PNS_IDX_PAGE_SEL: v = {2'h0, st.page};
      `PNS_IDX_BIT_OP:   v = {3'h0, st.bitop_rejected};
      default:
      begin
        // SRAM window or reserved slot
        if (idx >= `PNS_IDX_SRAM_LO && idx <= `PNS_IDX_SRAM_HI)
        begin
          v = ram_rdata;                                                // (RULE4)
        end
        else
        begin
          v = 4'h0;                                                     // (RULE21)
        end
      end
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign acc_idx   = paddr[8:2];
  assign addr_ok   = (paddr[31:9] == 23'h0) && (acc_idx <= `PNS_IDX_BIT_OP);
  assign acc_first = psel & penable & ~st.pready;
  assign acc_done  = psel & penable & st.pready;

  // ---------------------------------------------------------------
  // Bit set/clear command
  // ---------------------------------------------------------------
  assign bo_tgt = pwdata[`PNS_BO_TGT_MSB:0];
  assign bo_bit = pwdata[`PNS_BO_BIT_LSB+1:`PNS_BO_BIT_LSB];

  // Read-modify of the addressed nibble
  always_comb
  begin
    bo_cur         = nib_read({1'b0, bo_tgt}, 1'b1);
    bo_new         = bo_cur;
    bo_new[bo_bit] = pwdata[`PNS_BO_VALUE];
  end

  // ---------------------------------------------------------------
  // Single nibble write path
  // ---------------------------------------------------------------
  // Plain writes and accepted bit ops share it
  always_comb
  begin
    wr_en  = 1'b0;
    wr_idx = acc_idx;
    wr_val = pwdata[3:0];
    if (acc_done && pwrite && addr_ok)
    begin
      if (acc_idx == `PNS_IDX_BIT_OP)
      begin
        // Only the low sixteen slots take bit ops
        wr_en  = (bo_tgt <= `PNS_IDX_BITOP_LIMIT);                      // (RULE6)
        wr_idx = {1'b0, bo_tgt};
        wr_val = bo_new;
      end
      else
      begin
        wr_en  = 1'b1;                                                  // (RULE7)
      end
    end
  end

  // SRAM write in the page window only
  assign ram_wr = wr_en && (wr_idx >= `PNS_IDX_SRAM_LO) && (wr_idx <= `PNS_IDX_SRAM_HI);

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  // Four pages of 32 nibbles, page on top bits
  pns_nibble_ram #(
    .DEPTH    (128),
    .WIDTH    (4),
    .IDX_W    (7)
  ) u_ram (
    .pclk     (pclk),
    .wr_en    (ram_wr),
    .wr_index ({st.page, wr_idx[4:0]}),   // (RULE1)
    .wr_data  (wr_val),
    .rd_index ({st.page, acc_idx[4:0]}),  // (RULE4)
    .rd_data  (ram_rdata)
  );

  // Sample layout by fuse options
  pns_sample_pack u_pack (
    .xlo        (st.smp_xlo),
    .lo         (st.smp_lo),
    .hi         (st.smp_hi),
    .ten_bit    (ten_bit_option),
    .twelve_bit (twelve_bit_option),
    .sample     (asm_sample)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st        = st;
    next_st.sample = asm_sample;                                        // (RULE14)

    // APB answer: one wait state, then ready for a cycle
    next_st.pready = acc_first;
    if (acc_first)
    begin
      next_st.pslverr = ~addr_ok;
      next_st.prdata  = (pwrite || !addr_ok) ? 32'h0 : {28'h0, nib_read(acc_idx, 1'b0)};
    end
    else if (acc_done)
    begin
      next_st.pslverr = 1'b0;
    end

    // Core flag update, overridden by a software write
    if (alu_flag_load)
    begin
      next_st.flags[`PNS_ST_CARRY] = alu_carry;
      next_st.flags[`PNS_ST_ZERO]  = alu_zero;
    end

    // Page select load and bit op outcome
    if (acc_done && pwrite && addr_ok)
    begin
      if (acc_idx == `PNS_IDX_PAGE_SEL)
      begin
        next_st.page = pwdata[1:0];                                     // (RULE1)
      end
      if (acc_idx == `PNS_IDX_BIT_OP)
      begin
        next_st.bitop_rejected = (bo_tgt > `PNS_IDX_BITOP_LIMIT);       // (RULE6)
      end
    end

    // Register writes; common block independent of page
    if (wr_en)
    begin
      unique case (wr_idx)
        `PNS_IDX_STATUS:   next_st.flags     = wr_val[2:0];             // (RULE12)
        `PNS_IDX_E_DIR:    next_st.dir_n.e   = ~wr_val;                 // (RULE9)
        `PNS_IDX_A_DIR:    next_st.dir_n.a   = ~wr_val;
        `PNS_IDX_A_VAL:    next_st.latch.a   = wr_val;                  // (RULE10)
        `PNS_IDX_C_OUT:    next_st.port_c    = wr_val;                  // (RULE11)
        `PNS_IDX_B_DIR:    next_st.dir_n.b   = ~wr_val;
        `PNS_IDX_B_VAL:    next_st.latch.b   = wr_val;
        `PNS_IDX_SCRATCH1: next_st.scratch1  = wr_val;                  // (RULE8)
        `PNS_IDX_SMP_XLO:  next_st.smp_xlo   = wr_val;                  // (RULE15)
        `PNS_IDX_SMP_LO:   next_st.smp_lo    = wr_val;                  // (RULE14)
        `PNS_IDX_SMP_HI:   next_st.smp_hi    = wr_val;                  // (RULE17)
        `PNS_IDX_D_DIR:    next_st.dir_n.d   = ~wr_val;
        `PNS_IDX_D_VAL:    next_st.latch.d   = wr_val;
        `PNS_IDX_E_VAL:    next_st.latch.e   = wr_val;
        `PNS_IDX_SCRATCH2: next_st.scratch2  = wr_val;
        `PNS_IDX_PWM_CTRL:
        begin
          // Enables of PWM and global interrupt
          next_st.pwm_en = wr_val[`PNS_PC_PWM_EN];                      // (RULE13)
          next_st.gie    = wr_val[`PNS_PC_GIE];
        end
        `PNS_IDX_FMT_CTRL:
        begin
          // Format and hysteresis bits
          next_st.fmt_2s = wr_val[`PNS_FC_FMT];                         // (RULE18)
          next_st.hyst   = wr_val[`PNS_FC_HYST];                        // (RULE19)
        end
        default:
        begin
          // Reserved slots and SRAM: no register change
          next_st.flags = next_st.flags;                                // (RULE21)
        end
      endcase
    end

    // Request sets the flag; set wins over a clearing write
    if (pwm_irq_event)
    begin
      next_st.flags[`PNS_ST_PWM_IRQ] = 1'b1;                            // (RULE12)
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st                <= '0;
      st.flags          <= `PNS_RST_FLAGS;                              // (RULE12)
      st.dir_n          <= {4{`PNS_RST_DIR_N}};                         // (RULE9)
      st.latch          <= {4{`PNS_RST_NIBBLE}};
      st.port_c         <= `PNS_RST_NIBBLE;                             // (RULE11)
      st.scratch1       <= `PNS_RST_NIBBLE;
      st.scratch2       <= `PNS_RST_NIBBLE;
      st.smp_xlo        <= `PNS_RST_NIBBLE;
      st.smp_lo         <= `PNS_RST_NIBBLE;
      st.smp_hi         <= `PNS_RST_NIBBLE;
      st.pwm_en         <= 1'b0;                                        // (RULE13)
      st.gie            <= 1'b0;
      st.fmt_2s         <= 1'b0;                                        // (RULE18)
      st.hyst           <= 1'b0;                                        // (RULE19)
      st.page           <= `PNS_RST_PAGE;
      st.sample         <= `PNS_RST_SAMPLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, each straight from state
  // ---------------------------------------------------------------
  assign prdata                  = st.prdata;
  assign pready                  = st.pready;
  assign pslverr                 = st.pslverr;
  assign pin_out                 = st.latch;                            // (RULE10)
  assign pin_oe_n                = st.dir_n;                            // (RULE9)
  assign port_c_out              = st.port_c;
  assign pwm_sample              = st.sample;
  assign sample_sign             = st.smp_hi[3];                        // (RULE17)
  assign sample_format_select    = st.fmt_2s;
  assign pwm_output_enable       = st.pwm_en;
  assign global_irq_enable       = st.gie;
  assign pwm_irq_flag            = st.flags[`PNS_ST_PWM_IRQ];
  assign hysteresis_input_enable = st.hyst;
  assign page_select             = st.page;                             // (RULE2)

endmodule // pns_bank

// ==== pns_bank_monitor.sv ====
// Port-level checker of the paged nibble bank
`timescale 1ns/10ps
module pns_bank_monitor (
  input wire logic              pclk,          // Clock
  input wire logic              presetn,       // Reset, low
  input wire logic              psel,          // Select
  input wire logic              penable,       // Enable
  input wire logic              pwrite,        // Direction
  input wire logic [31:0]       paddr,         // Address
  input wire logic [31:0]       pwdata,        // Write data
  input wire logic [31:0]       prdata,        // Read data
  input wire logic              pready,        // Ready
  input wire logic              pslverr,       // Error
  input wire pns_pkg::pns_pins_t pin_oe_n,     // Pin enables
  input wire logic [3:0]        port_c_out,    // Port C
  input wire logic              pwm_irq_event, // Irq pulse
  input wire logic              pwm_irq_flag,  // Irq flag
  input wire logic [1:0]        page_select    // Page
);
  import pns_pkg::*;
  logic [6:0] idx;  // Register index
  logic       done; // Transfer completes
  assign idx = paddr[8:2];
  assign done = psel && penable && pready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  AST_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_RST: assert property ($rose(presetn) |-> pin_oe_n == 16'hFFFF && port_c_out == 4'h0)
    else $error("pins not released after reset");
  AST_DIR: assert property (done && pwrite && idx == 7'h02 |=> pin_oe_n.a == ~$past(pwdata[3:0]))
    else $error("port A direction not applied");
  AST_PC: assert property (done && pwrite && idx == 7'h04 |=> port_c_out == $past(pwdata[3:0]))
    else $error("port C not driven");
  AST_RSVD: assert property (done && !pwrite && (idx == 7'h10 || idx == 7'h12) |-> prdata == 32'h0 && !pslverr)
    else $error("reserved read not quiet");
  AST_WO: assert property (done && !pwrite && idx == 7'h0B |-> prdata == 32'h0)
    else $error("write-only nibble readable");
  AST_IRQ: assert property (pwm_irq_event |=> pwm_irq_flag)
    else $error("irq flag not set");
  AST_PAGE: assert property (done && pwrite && idx == 7'h40 |=> page_select == $past(pwdata[1:0]))
    else $error("page select not loaded");
  C_PAGE: cover property (done && pwrite && idx == 7'h40);
  C_IRQ: cover property (pwm_irq_event);
  C_RSVD: cover property (done && idx == 7'h10);
endmodule // pns_bank_monitor
bind pns_bank pns_bank_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pin_oe_n(pin_oe_n), .port_c_out(port_c_out),
  .pwm_irq_event(pwm_irq_event), .pwm_irq_flag(pwm_irq_flag), .page_select(page_select));

// ==== pns_defs.svh ====
// Offsets, field positions, reset values and limits of the paged nibble register bank
`ifndef PNS_DEFS_SVH
`define PNS_DEFS_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define PNS_IDX_STATUS       7'h00
`define PNS_IDX_E_DIR        7'h01
`define PNS_IDX_A_DIR        7'h02
`define PNS_IDX_A_VAL        7'h03
`define PNS_IDX_C_OUT        7'h04
`define PNS_IDX_B_DIR        7'h05
`define PNS_IDX_B_VAL        7'h06
`define PNS_IDX_SCRATCH1     7'h07
`define PNS_IDX_SMP_XLO      7'h08
`define PNS_IDX_PWM_CTRL     7'h09
`define PNS_IDX_SMP_LO       7'h0A
`define PNS_IDX_SMP_HI       7'h0B
`define PNS_IDX_D_DIR        7'h0C
`define PNS_IDX_D_VAL        7'h0D
`define PNS_IDX_E_VAL        7'h0E
`define PNS_IDX_SCRATCH2     7'h0F
`define PNS_IDX_RSVD_A       7'h10
`define PNS_IDX_FMT_CTRL     7'h11
`define PNS_IDX_RSVD_B       7'h12
`define PNS_IDX_SRAM_LO      7'h20
`define PNS_IDX_SRAM_HI      7'h3F
`define PNS_IDX_PAGE_SEL     7'h40
`define PNS_IDX_BIT_OP       7'h41
`define PNS_IDX_BITOP_LIMIT  6'h0F

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PNS_ST_ZERO          0
`define PNS_ST_CARRY         1
`define PNS_ST_PWM_IRQ       2
`define PNS_PC_PWM_EN        0
`define PNS_PC_GIE           1
`define PNS_FC_FMT           1
`define PNS_FC_HYST          2
`define PNS_BO_TGT_MSB       5
`define PNS_BO_BIT_LSB       6
`define PNS_BO_VALUE         8

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define PNS_RST_NIBBLE       4'h0
`define PNS_RST_DIR_N        4'hF
`define PNS_RST_PAGE         2'h0
`define PNS_RST_FLAGS        3'h0
`define PNS_RST_SAMPLE       12'h000

`endif

// ==== pns_nibble_ram.sv ====
// Flip-flop nibble store for the paged user SRAM
`timescale 1ns/10ps

module pns_nibble_ram #(
  parameter int DEPTH = 128,  // Nibbles
  parameter int WIDTH = 4,    // Bits per entry
  parameter int IDX_W = 7     // Index width
) (
  input  wire logic             pclk,     // Clock
  input  wire logic             wr_en,    // Write strobe
  input  wire logic [IDX_W-1:0] wr_index, // Write entry
  input  wire logic [WIDTH-1:0] wr_data,  // Write nibble
  input  wire logic [IDX_W-1:0] rd_index, // Read entry
  output logic      [WIDTH-1:0] rd_data   // Read nibble
);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage, no reset

  // ---------------------------------------------------------------
  // One write port per entry; contents stay unset after reset
  // ---------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    always_ff @(posedge pclk)
    begin
      if (wr_en && (wr_index == IDX_W'(i)))
      begin
        mem[i] <= wr_data;  // (RULE5)
      end
    end
  end

  // Asynchronous read
  assign rd_data = mem[rd_index];

endmodule // pns_nibble_ram

// ==== pns_pin_world.sv ====
// Pin-side model of the bank's four bidirectional ports
`timescale 1ns/10ps
module pns_pin_world #(
  parameter int EXT = 'hA5C3 // Outside level on released pins
) (
  input wire pns_pkg::pns_pins_t pin_out,  // Output latches
  input wire pns_pkg::pns_pins_t pin_oe_n, // Enables, low drives
  output pns_pkg::pns_pins_t     pin_in    // Levels seen by the bank
);
  import pns_pkg::*;
  // Driven pins echo the latch, released pins show the outside level
  assign pin_in = (pin_out & ~pin_oe_n) | (16'(EXT) & pin_oe_n);
endmodule // pns_pin_world

// ==== pns_pkg.sv ====
// Types shared by the paged nibble register bank
package pns_pkg;

  // ---------------------------------------------------------------
  // Pin group of the four bidirectional ports
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] a;  // Port A
    logic [3:0] b;  // Port B
    logic [3:0] d;  // Port D
    logic [3:0] e;  // Port E
  } pns_pins_t;

  // ---------------------------------------------------------------
  // Whole state of the bank
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        pready;          // APB ready
    logic        pslverr;         // APB error
    logic [31:0] prdata;          // APB read data
    logic [2:0]  flags;           // Irq, carry, zero
    pns_pins_t   dir_n;           // Inverted directions (1 = input)
    pns_pins_t   latch;           // Output latches
    logic [3:0]  port_c;          // Port C output
    logic [3:0]  scratch1;        // Scratch nibble one
    logic [3:0]  scratch2;        // Scratch nibble two
    logic [3:0]  smp_xlo;         // Sample extra low
    logic [3:0]  smp_lo;          // Sample low
    logic [3:0]  smp_hi;          // Sample high
    logic        pwm_en;          // PWM output enable
    logic        gie;             // Global irq enable
    logic        fmt_2s;          // Two's complement format
    logic        hyst;            // Hysteresis input enable
    logic [1:0]  page;            // SRAM page select
    logic        bitop_rejected;  // Last bit op refused
    logic [11:0] sample;          // Assembled sample
  } pns_state_t;

endpackage

// ==== pns_sample_pack.sv ====
// Assembles the PWM sample from its three write-only nibbles
`timescale 1ns/10ps

module pns_sample_pack (
  input  wire logic [3:0]  xlo,        // Extra low nibble
  input  wire logic [3:0]  lo,         // Low nibble
  input  wire logic [3:0]  hi,         // High nibble
  input  wire logic        ten_bit,    // Ten bit option
  input  wire logic        twelve_bit, // Twelve bit option
  output logic      [11:0] sample      // Right aligned sample
);

  // ---------------------------------------------------------------
  // Resolution select
  // ---------------------------------------------------------------
  // Twelve bit overrides ten bit; eight bit otherwise
  always_comb
  begin
    if (twelve_bit)
    begin
      sample = {hi, lo, xlo};             // (RULE16)
    end
    else if (ten_bit)
    begin
      sample = {2'h0, hi, lo, xlo[3:2]};  // (RULE15)
    end
    else
    begin
      sample = {4'h0, hi, lo};            // (RULE14)
    end
  end

endmodule // pns_sample_pack

// ==== tb_top.sv ====
// Self-checking bench of the paged nibble bank
`timescale 1ns/10ps
module tb_top;
  import pns_pkg::*;
  localparam int EXT = 'hA5C3; // Outside pin level
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic irq_ev = 0, fl_ld = 0, cy = 0, zr = 0, ten = 0, twelve = 0;
  logic fmt, pen, gie, irqf, hyst, sgn;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd, seed = 32'h1CCAB85C;
  logic [11:0] smp;
  logic [3:0] pc_out;
  logic [1:0] page;
  pns_pins_t pin_in, pin_out, oe_n;
  int err_total = 0, compares = 0, cyc = 0, v, x, l, h, mdl[int], sram[128];
  int rw[8] = '{1, 2, 5, 12, 7, 15, 4, 9}, pv[4] = '{3, 6, 13, 14}, pd[4] = '{2, 5, 12, 1};
  pns_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(oe_n),
    .port_c_out(pc_out), .pwm_irq_event(irq_ev), .alu_flag_load(fl_ld), .alu_carry(cy),
    .alu_zero(zr), .ten_bit_option(ten), .twelve_bit_option(twelve), .pwm_sample(smp),
    .sample_sign(sgn), .sample_format_select(fmt), .pwm_output_enable(pen),
    .global_irq_enable(gie), .pwm_irq_flag(irqf), .hysteresis_input_enable(hyst),
    .page_select(page));
  pns_pin_world #(.EXT(EXT)) i_pins (.pin_out(pin_out), .pin_oe_n(oe_n), .pin_in(pin_in));
  always #10 pclk = ~pclk;
  // Hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      end_sim();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic w, input int i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {23'h0, 7'(i), 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input int i, input int d);
    apb(1'b1, i, d);
    @(negedge pclk);
  endtask
  task automatic rc(input string nm, input int i, input int e);
    int m;
    m = (i == 9) ? 3 : (i == 17) ? 6 : (i == 0) ? 7 : (i == 65) ? 1 : 15;
    apb(1'b0, i, 0);
    chk(nm, e & m, rd & m);
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rw[k]) rc("reset", rw[k], 0);
    rc("reset_fmt", 17, 0);
    foreach (rw[k])
    begin
      mdl[rw[k]] = xs() & 15;
      wr(rw[k], mdl[rw[k]]);
    end
    foreach (rw[k]) rc("rw", rw[k], mdl[rw[k]]);
    chk("oe_n", 16'(~{4'(mdl[2]), 4'(mdl[5]), 4'(mdl[12]), 4'(mdl[1])}), oe_n);
    chk("port_c", mdl[4], pc_out);
    chk("pwm_ctl", mdl[9] & 3, {gie, pen});
    for (int k = 0; k < 4; k++)
    begin
      v = xs() & 15;
      wr(pv[k], v);
      x = (mdl[pd[k]] & v) | (~mdl[pd[k]] & (EXT >> (12 - 4 * k)) & 15);
      rc("port_in", pv[k], x);
      chk("pin_out", v, pin_out[15 - 4 * k -: 4]);
    end
    $display("registers and ports done");
    for (int p = 0; p < 4; p++)
    begin
      wr(64, p);
      for (int j = 0; j < 32; j++)
      begin
        sram[p * 32 + j] = xs() & 15;
        wr(32 + j, sram[p * 32 + j]);
      end
    end
    for (int p = 0; p < 4; p++)
    begin
      wr(64, p);
      chk("page", p, page);
      for (int j = 0; j < 32; j++) rc("sram", 32 + j, sram[p * 32 + j]);
      rc("common", 7, mdl[7]);
    end
    $display("paged memory done");
    wr(65, 'h187);
    wr(65, 'h00F);
    rc("bit_set", 7, mdl[7] | 4);
    rc("bit_clr", 15, mdl[15] & 14);
    wr(65, 'h151);
    rc("bit_refused", 65, 1);
    rc("no_bit_op", 17, 0);
    wr(17, 6);
    chk("fmt_hyst", 3, {hyst, fmt});
    $display("bit operations done");
    for (int m = 0; m < 3; m++)
    begin
      ten <= (m == 1);
      twelve <= (m == 2);
      x = xs() & 15;
      l = xs() & 15;
      h = xs() & 15;
      wr(8, x);
      wr(10, l);
      wr(11, h);
      repeat (3) @(posedge pclk);
      v = (m == 2) ? (h << 8 | l << 4 | x) : (m == 1) ? (h << 6 | l << 2 | x >> 2) : (h << 4 | l);
      chk("sample", v, smp);
      chk("sign", h >> 3, sgn);
      rc("write_only", 10, 0);
    end
    wr(16, 15);
    rc("reserved", 16, 0);
    apb(1'b0, 80, 0);
    chk("unmapped", 1, er);
    $display("samples and reserved done");
    irq_ev <= 1'b1;
    fl_ld <= 1'b1;
    {cy, zr} <= 2'b11;
    @(posedge pclk);
    irq_ev <= 1'b0;
    fl_ld <= 1'b0;
    @(posedge pclk);
    chk("irq_flag", 1, irqf);
    rc("status", 0, 7);
    wr(0, 0);
    rc("status_clr", 0, 0);
    $display("flags done");
    end_sim();
  end
endmodule // tb_top
